/* hdl/dsd_top.sv */
/*
  dsd_top: control of two sigma-delta converter channels (current, voltage/temperature):
  mode, mux and reference selection, decimation, settling, counter, comparator, accumulator.
  assumes an APB master and analog modulators sampled on the modulator strobe;
  inputs are synchronous to clk_sys.
*/
// Behaviour
// R1: current result is 20-bit signed, 19 magnitude bits and sign
// R2: current channel mux offers five differential pairs
// R3: voltage/temperature mux offers seven pairs
// R4: four reference choices per channel, external pin after reset
// R5: each channel has its own reference setting
// R6: selectable sinc3/sinc4 filter with programmable decimation per channel; one FILT register sets both channels
// R7: current channel interrupts on conversion count or threshold exceed
// R8: optional accumulation of each current result into 32 bits
// R9: continuous interrupt option also signals unsettled results
// R10: voltage channel settles three conversions after configuration, chop off; the code waits four conversions when sinc4 is selected
// R11: one mode bit selects reduced or full power, independent of processor
// R12: full power enables both channels, modulators at 512 kHz
// R13: software normally uses full power, 1 kHz rate, chop on
// R14: safety use selects internal 1.2 V reference with buffer enabled
// R15: reduced power keeps only current channel, modulator at 128 kHz
// R16: mode 2 runs one conversion then idle; mode 1 runs continuously
// R17: ready flag per conversion; range error sets error bit, result invalid
// R18: count conversions after reconfiguration, tag settled after settling count
`timescale 1ns/1ps
module dsd_top
  import dsd_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic [31:0]                   prdata,
  input  wire logic                     modBit0,
  input  wire logic                     modBit1,
  input  wire logic                     rangeErr0,
  input  wire logic                     rangeErr1,
  output logic                          modClk,
  output logic                          chan0Enable,
  output logic                          chan1Enable,
  output logic [2:0]                    mux0Sel,
  output logic [2:0]                    mux1Sel,
  output logic [1:0]                    ref0Sel,
  output logic [1:0]                    ref1Sel,
  output logic                          chopEnable,
  output logic                          irq
);
  logic [31:0] mode_ff, nxt_mode;
  logic [31:0] cfg0_ff, nxt_cfg0;
  logic [31:0] cfg1_ff, nxt_cfg1;
  logic [31:0] filt_ff, nxt_filt;
  logic [31:0] ien_ff, nxt_ien;
  logic [31:0] cntLim_ff, nxt_cntLim;
  logic [RES_W-1:0] thr_ff, nxt_thr;
  logic [RES_W:0] res0_ff, nxt_res0;
  logic [RES_W:0] res1_ff, nxt_res1;
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] stat_ff, nxt_stat;
  logic [3:0] settle0_ff, nxt_settle0, settle1_ff, nxt_settle1;
  dsd_conv_e conv_ff, nxt_conv;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic irq_ff, nxt_irq;
  logic en0_ff, nxt_en0, en1_ff, nxt_en1;

  logic lowPower, running, wrAcc, rdAcc, reconf;
  logic modStb, modClkInt;
  logic done0, done1;
  logic [RES_W-1:0] data0, data1;
  logic [3:0] settleTgt;
  logic [31:0] rdMux;

  assign lowPower = mode_ff[MODE_LP_BIT];  // [R11]
  assign running  = (conv_ff != DSD_IDLE);
  // a write lands at the edge where the master samples pready high
  assign wrAcc    = psel && penable && pwrite && pready_ff;
  assign rdAcc    = psel && penable && !pwrite && !pready_ff;
  assign settleTgt = dsd_settle(filt_ff[FLT_SINC4_BIT], filt_ff[FLT_CHOP_BIT]);  // [R10]
  assign reconf   = wrAcc && (paddr == OFF_CFG0 || paddr == OFF_CFG1 || paddr == OFF_FILT ||
                              paddr == OFF_MODE);

  dsd_modclk u_modclk (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .lowPower (lowPower),
    .modClk   (modClkInt),
    .modStb   (modStb)
  );

  dsd_decim #(.DEC_W(DEC_W), .OUT_W(RES_W)) u_dec0 (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .enable  (en0_ff),
    .modStb  (modStb),
    .bitIn   (modBit0),
    .sinc4   (filt_ff[FLT_SINC4_BIT]),
    .decRate (filt_ff[FLT_DEC_LSB +: DEC_W]),
    .outStb  (done0),
    .outData (data0)
  );

  dsd_decim #(.DEC_W(DEC_W), .OUT_W(RES_W)) u_dec1 (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .enable  (en1_ff),
    .modStb  (modStb),
    .bitIn   (modBit1),
    .sinc4   (filt_ff[FLT_SINC4_BIT]),
    .decRate (filt_ff[FLT_DEC_LSB +: DEC_W]),
    .outStb  (done1),
    .outData (data1)
  );

  // register writes
  always_comb begin
    nxt_mode   = mode_ff;
    nxt_cfg0   = cfg0_ff;
    nxt_cfg1   = cfg1_ff;
    nxt_filt   = filt_ff;
    nxt_ien    = ien_ff;
    nxt_cntLim = cntLim_ff;
    nxt_thr    = thr_ff;
    if (wrAcc) begin
      case (paddr)
        OFF_MODE:   nxt_mode = {28'h000_0000, pwdata[3:0]};  // [R11] [R16]
        OFF_CFG0: begin
          nxt_cfg0 = {22'h00_0000, pwdata[9:0]};  // [R5]
          // out-of-list mux codes fold to the shorted pair, never an undefined route
          if (pwdata[CFG_MUX_LSB +: 3] > MUX0_MAX) nxt_cfg0[CFG_MUX_LSB +: 3] = 3'h1;  // [R2]
        end
        OFF_CFG1: begin
          nxt_cfg1 = {22'h00_0000, pwdata[9:0]};  // [R5]
          if (pwdata[CFG_MUX_LSB +: 3] > MUX1_MAX) nxt_cfg1[CFG_MUX_LSB +: 3] = 3'h4;  // [R3]
        end
        OFF_FILT: begin
          nxt_filt = {16'h0000, pwdata[15:0]};  // [R6]
          if (pwdata[FLT_DEC_LSB +: DEC_W] < DEC_MIN) nxt_filt[FLT_DEC_LSB +: DEC_W] = DEC_MIN;
        end
        OFF_IEN:    nxt_ien = {28'h000_0000, pwdata[IRQ_W-1:0]};
        OFF_CNTLIM: nxt_cntLim = {16'h0000, pwdata[15:0]};
        OFF_THR:    nxt_thr = pwdata[RES_W-1:0];
        default: begin
        end
      endcase
    end
    // single conversion clears its own start once the result is in
    if (conv_ff == DSD_LAST && done0 && !(wrAcc && paddr == OFF_MODE))
      nxt_mode[1:0] = MODE_IDLE;  // [R16]
  end

  // conversion sequencing
  always_comb begin
    nxt_conv = conv_ff;
    case (conv_ff)
      DSD_IDLE: begin
        if (mode_ff[1:0] == MODE_CONT) nxt_conv = DSD_RUN;  // [R16]
        else if (mode_ff[1:0] == MODE_SINGLE) nxt_conv = DSD_LAST;
      end
      DSD_RUN:  if (mode_ff[1:0] != MODE_CONT) nxt_conv = DSD_IDLE;
      DSD_LAST: if (done0 || mode_ff[1:0] != MODE_SINGLE) nxt_conv = DSD_IDLE;
      default:  nxt_conv = DSD_IDLE;
    endcase
    nxt_en0 = (nxt_conv != DSD_IDLE);  // [R12] [R15]
    nxt_en1 = (nxt_conv != DSD_IDLE) && !lowPower;  // [R15]
  end

  // results, settling, counter, comparator, accumulator, status
  always_comb begin
    logic settled0, settled1, st0, st1, over;
    settled0 = 1'b0;
    settled1 = 1'b0;
    st0 = 1'b0;
    st1 = 1'b0;
    over = 1'b0;
    nxt_res0 = res0_ff;
    nxt_res1 = res1_ff;
    nxt_acc  = acc_ff;
    nxt_cnt  = cnt_ff;
    nxt_stat = stat_ff;
    nxt_settle0 = settle0_ff;
    nxt_settle1 = settle1_ff;
    if (reconf || !running) begin
      nxt_settle0 = '0;  // [R18]
      nxt_settle1 = '0;
    end
    if (done0 && running) begin
      if (settle0_ff < settleTgt) nxt_settle0 = settle0_ff + 4'h1;  // [R18]
      settled0 = (settle0_ff + 4'h1 >= settleTgt);
      nxt_res0 = {rangeErr0, data0};  // [R1] [R17]
      st0 = settled0 || cfg0_ff[CFG_CIE_BIT];  // [R9]
      if (st0) begin
        nxt_stat[ST_RDY0] = 1'b1;  // [R17]
        if (rangeErr0) nxt_stat[ST_ERR0] = 1'b1;
        if (cfg0_ff[CFG_ACC_BIT] && !rangeErr0)
          nxt_acc = acc_ff + ACC_W'($signed(data0));  // [R8]
        over = $signed(data0) > $signed(thr_ff);
        if (over) nxt_stat[IRQ_THR] = 1'b1;  // [R7]
        if (cnt_ff + 16'h0001 >= cntLim_ff[15:0] && cntLim_ff[15:0] != 16'h0000) begin
          nxt_stat[IRQ_CNT] = 1'b1;  // [R7]
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
    end
    if (done1 && running && !lowPower) begin
      if (settle1_ff < settleTgt) nxt_settle1 = settle1_ff + 4'h1;  // [R10]
      settled1 = (settle1_ff + 4'h1 >= settleTgt);
      nxt_res1 = {rangeErr1, data1};
      st1 = settled1 || cfg1_ff[CFG_CIE_BIT];  // [R9]
      if (st1) begin
        nxt_stat[ST_RDY1] = 1'b1;  // [R17]
        if (rangeErr1) nxt_stat[ST_ERR1] = 1'b1;
      end
    end
    if (wrAcc && paddr == OFF_ACC) nxt_acc = pwdata;
    if (wrAcc && paddr == OFF_CNT) nxt_cnt = pwdata[15:0];
    // clear loses to a set in the same cycle
    if (wrAcc && paddr == OFF_ICLR) begin
      nxt_stat[ST_RDY0] = nxt_stat[ST_RDY0] & ~(pwdata[ST_RDY0] & ~(done0 & st0));
      nxt_stat[ST_RDY1] = nxt_stat[ST_RDY1] & ~(pwdata[ST_RDY1] & ~(done1 & st1));
      nxt_stat[IRQ_CNT] = nxt_stat[IRQ_CNT] & ~(pwdata[IRQ_CNT] & ~(done0 & st0 & nxt_cnt == 16'h0000));
      nxt_stat[IRQ_THR] = nxt_stat[IRQ_THR] & ~(pwdata[IRQ_THR] & ~(done0 & st0 & over));
      nxt_stat[ST_ERR0] = nxt_stat[ST_ERR0] & ~(pwdata[ST_ERR0] & ~(done0 & st0 & rangeErr0));
      nxt_stat[ST_ERR1] = nxt_stat[ST_ERR1] & ~(pwdata[ST_ERR1] & ~(done1 & st1 & rangeErr1));
    end
  end

  // apb read path and answer
  always_comb begin
    case (paddr)
      OFF_MODE:   rdMux = mode_ff;
      OFF_CFG0:   rdMux = cfg0_ff;
      OFF_CFG1:   rdMux = cfg1_ff;
      OFF_FILT:   rdMux = filt_ff;
      OFF_RES0:   rdMux = {11'h000, res0_ff};
      OFF_RES1:   rdMux = {11'h000, res1_ff};
      OFF_STAT:   rdMux = {16'h0000, stat_ff};
      OFF_IEN:    rdMux = ien_ff;
      OFF_CNTLIM: rdMux = cntLim_ff;
      OFF_THR:    rdMux = {12'h000, thr_ff};
      OFF_ACC:    rdMux = acc_ff;
      OFF_CNT:    rdMux = {16'h0000, cnt_ff};
      default:    rdMux = 32'h0000_0000;
    endcase
    nxt_pready  = psel && penable && !pready_ff;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    if (rdAcc) nxt_prdata = rdMux;
    if (nxt_pready && (paddr[1:0] != 2'b00 || paddr > OFF_CNT)) nxt_pslverr = 1'b1;
    nxt_irq = |(nxt_stat[IRQ_W-1:0] & ien_ff[IRQ_W-1:0]) ||
              (ien_ff[0] && (nxt_stat[ST_ERR0] || nxt_stat[ST_ERR1]));
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_ff    <= '0;
      cfg0_ff    <= '0;  // [R4]
      cfg1_ff    <= '0;
      filt_ff    <= {16'h0000, 4'h0, DEC_RESET};
      ien_ff     <= '0;
      cntLim_ff  <= '0;
      thr_ff     <= '0;
      res0_ff    <= '0;
      res1_ff    <= '0;
      acc_ff     <= '0;
      cnt_ff     <= '0;
      stat_ff    <= '0;
      settle0_ff <= '0;
      settle1_ff <= '0;
      conv_ff    <= DSD_IDLE;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
      irq_ff     <= 1'b0;
      en0_ff     <= 1'b0;
      en1_ff     <= 1'b0;
    end else begin
      mode_ff    <= nxt_mode;
      cfg0_ff    <= nxt_cfg0;
      cfg1_ff    <= nxt_cfg1;
      filt_ff    <= nxt_filt;
      ien_ff     <= nxt_ien;
      cntLim_ff  <= nxt_cntLim;
      thr_ff     <= nxt_thr;
      res0_ff    <= nxt_res0;
      res1_ff    <= nxt_res1;
      acc_ff     <= nxt_acc;
      cnt_ff     <= nxt_cnt;
      stat_ff    <= nxt_stat;
      settle0_ff <= nxt_settle0;
      settle1_ff <= nxt_settle1;
      conv_ff    <= nxt_conv;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
      irq_ff     <= nxt_irq;
      en0_ff     <= nxt_en0;
      en1_ff     <= nxt_en1;
    end
  end

  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign prdata      = prdata_ff;
  assign irq         = irq_ff;
  assign modClk      = modClkInt;
  assign chan0Enable = en0_ff;
  assign chan1Enable = en1_ff;
  assign mux0Sel     = cfg0_ff[CFG_MUX_LSB +: 3];
  assign mux1Sel     = cfg1_ff[CFG_MUX_LSB +: 3];
  assign ref0Sel     = cfg0_ff[CFG_REF_LSB +: 2];  // [R4] [R5]
  assign ref1Sel     = cfg1_ff[CFG_REF_LSB +: 2];
  assign chopEnable  = filt_ff[FLT_CHOP_BIT];
endmodule

/* pkg/dsd_pkg.sv */
/*
  dsd_pkg: offsets, fields, reset values and timing constants.
  assumes a 10 MHz system clock and an APB bus with 32-bit data.
*/
package dsd_pkg;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned NORM_MOD_HZ    = 512_000;
  localparam int unsigned LOWP_MOD_HZ    = 128_000;
  localparam int unsigned NORM_MOD_DIV   = CLK_HZ / NORM_MOD_HZ;
  localparam int unsigned LOWP_MOD_DIV   = CLK_HZ / LOWP_MOD_HZ;
  localparam int unsigned RES_W          = 20;
  localparam int unsigned ACC_W          = 32;
  localparam int unsigned DEC_W          = 12;
  localparam int unsigned SETTLE_DEF     = 3;

  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CFG0   = 8'h04;
  localparam logic [7:0] OFF_CFG1   = 8'h08;
  localparam logic [7:0] OFF_FILT   = 8'h0C;
  localparam logic [7:0] OFF_RES0   = 8'h10;
  localparam logic [7:0] OFF_RES1   = 8'h14;
  localparam logic [7:0] OFF_STAT   = 8'h18;
  localparam logic [7:0] OFF_IEN    = 8'h1C;
  localparam logic [7:0] OFF_ICLR   = 8'h20;
  localparam logic [7:0] OFF_CNTLIM = 8'h24;
  localparam logic [7:0] OFF_THR    = 8'h28;
  localparam logic [7:0] OFF_ACC    = 8'h2C;
  localparam logic [7:0] OFF_CNT    = 8'h30;

  localparam logic [1:0] MODE_IDLE  = 2'h0;
  localparam logic [1:0] MODE_CONT  = 2'h1;
  localparam logic [1:0] MODE_SINGLE= 2'h2;
  localparam int unsigned MODE_LP_BIT = 3;

  localparam int unsigned CFG_MUX_LSB = 0;
  localparam int unsigned CFG_REF_LSB = 4;
  localparam int unsigned CFG_ACC_BIT = 8;
  localparam int unsigned CFG_CIE_BIT = 9;
  localparam logic [2:0] MUX0_MAX = 3'h4;
  localparam logic [2:0] MUX1_MAX = 3'h6;
  localparam logic [1:0] REF_EXT  = 2'h0;

  localparam int unsigned FLT_DEC_LSB  = 0;
  localparam int unsigned FLT_SINC4_BIT= 12;
  localparam int unsigned FLT_CHOP_BIT = 15;
  localparam logic [DEC_W-1:0] DEC_RESET = 12'h01F;
  localparam logic [DEC_W-1:0] DEC_MIN   = 12'h001;

  localparam int unsigned ST_RDY0 = 0;
  localparam int unsigned ST_RDY1 = 1;
  localparam int unsigned ST_ERR0 = 12;
  localparam int unsigned ST_ERR1 = 13;
  localparam int unsigned IRQ_CNT = 2;
  localparam int unsigned IRQ_THR = 3;
  localparam int unsigned IRQ_W   = 4;

  typedef enum logic [1:0] {
    DSD_IDLE = 2'b00,
    DSD_RUN  = 2'b01,
    DSD_LAST = 2'b11
  } dsd_conv_e;

  function automatic logic [3:0] dsd_settle(input logic sinc4, input logic chop);
    dsd_settle = chop ? 4'h2 : (sinc4 ? 4'h4 : 4'h3);
  endfunction
endpackage

/* hdl/dsd_decim.sv */
/*
  dsd_decim: sinc3/sinc4 decimator for one modulator bitstream.
  assumes bitIn is valid on each modStb pulse; decRate is held while enabled.
*/
`timescale 1ns/1ps
module dsd_decim #(
  parameter int unsigned DEC_W = 12,
  parameter int unsigned OUT_W = 20
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             enable,
  input  wire logic             modStb,
  input  wire logic             bitIn,
  input  wire logic             sinc4,
  input  wire logic [DEC_W-1:0] decRate,
  output logic                  outStb,
  output logic [OUT_W-1:0]      outData
);
  localparam int unsigned AW = 4 * DEC_W + 2;
  initial begin
    if (OUT_W > AW) $error("dsd_decim: output wider than accumulator");
  end
  logic [AW-1:0] int_ff [4];
  logic [AW-1:0] nxt_int [4];
  logic [AW-1:0] nxt_dif [4];
  logic [AW-1:0] dly_ff [4];
  logic [AW-1:0] nxt_dly [4];
  logic [DEC_W-1:0] cnt_ff, nxt_cnt;
  logic outStb_ff, nxt_outStb;
  logic [OUT_W-1:0] out_ff, nxt_out;
  logic [AW-1:0] x, d;

  always_comb begin
    x = bitIn ? AW'(1) : {AW{1'b1}};
    nxt_int = int_ff;
    nxt_dif = '{default: '0};
    nxt_dly = dly_ff;
    nxt_cnt = cnt_ff;
    nxt_outStb = 1'b0;
    nxt_out = out_ff;
    d = '0;
    if (!enable) begin
      for (int i = 0; i < 4; i++) begin
        nxt_int[i] = '0;
        nxt_dly[i] = '0;
      end
      nxt_cnt = '0;
    end else if (modStb) begin
      nxt_int[0] = int_ff[0] + x;
      for (int i = 1; i < 4; i++) nxt_int[i] = int_ff[i] + int_ff[i-1];
      if (cnt_ff >= decRate - DEC_W'(1)) begin
        nxt_cnt = '0;
        d = sinc4 ? int_ff[3] : int_ff[2];
        for (int i = 0; i < 4; i++) begin
          nxt_dly[i] = d;
          d = d - dly_ff[i];
          nxt_dif[i] = d;
        end
        // sinc3 uses three comb stages; the fourth is bypassed
        nxt_out = sinc4 ? d[AW-1 -: OUT_W] : nxt_dif[2][AW-1 -: OUT_W];
        nxt_outStb = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + DEC_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        int_ff[i] <= '0;
        dly_ff[i] <= '0;
      end
      cnt_ff    <= '0;
      outStb_ff <= 1'b0;
      out_ff    <= '0;
    end else begin
      int_ff    <= nxt_int;
      dly_ff    <= nxt_dly;
      cnt_ff    <= nxt_cnt;
      outStb_ff <= nxt_outStb;
      out_ff    <= nxt_out;
    end
  end
  assign outStb  = outStb_ff;
  assign outData = out_ff;
endmodule

/* hdl/dsd_modclk.sv */
/*
  dsd_modclk: modulator clock generator, full or reduced rate.
  assumes the system clock rate of dsd_pkg.
*/
`timescale 1ns/1ps
module dsd_modclk
  import dsd_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic lowPower,
  output logic      modClk,
  output logic      modStb
);
  logic [7:0] div_ff, nxt_div;
  logic clk_ff, nxt_clk;
  logic stb_ff, nxt_stb;
  logic [7:0] lim;

  always_comb begin
    lim = lowPower ? 8'(LOWP_MOD_DIV - 1) : 8'(NORM_MOD_DIV - 1);
    nxt_stb = 1'b0;
    nxt_clk = clk_ff;
    if (div_ff >= lim) begin
      nxt_div = '0;
      nxt_stb = 1'b1;
      nxt_clk = 1'b1;
    end else begin
      nxt_div = div_ff + 8'h01;
      if (div_ff == (lim >> 1)) nxt_clk = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_ff <= '0;
      clk_ff <= 1'b0;
      stb_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      clk_ff <= nxt_clk;
      stb_ff <= nxt_stb;
    end
  end
  assign modClk = clk_ff;
  assign modStb = stb_ff;
endmodule

/* tb/dsd_mod_model.sv */
/*
  dsd_mod_model: stand-in for both analog modulators and range detectors.
  assumes modClk from the design; bits step on its rising edge only.
*/
`timescale 1ns/1ps
module dsd_mod_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       modClk,
  input  wire logic       chan0Enable,
  input  wire logic       chan1Enable,
  input  wire logic [2:0] density,
  input  wire logic       rangeOn,
  output logic            modBit0,
  output logic            modBit1,
  output logic            rangeErr0,
  output logic            rangeErr1
);
  logic [2:0] phase;
  logic       clkOld;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase  <= 3'h0;
      clkOld <= 1'b0;
    end else begin
      clkOld <= modClk;
      if (modClk && !clkOld) begin
        phase <= phase + 3'h1;
      end
    end
  end
  // a powered-down channel gives a toggling line, never a frozen one
  assign modBit0   = chan0Enable ? (phase < density) : phase[0];
  assign modBit1   = chan1Enable ? (phase < density) : !phase[0];
  assign rangeErr0 = rangeOn && chan0Enable;
  assign rangeErr1 = rangeOn && chan1Enable;
endmodule

/* tb/dsd_top_chk.sv */
/*
  dsd_top_chk: port-level assertions for dsd_top.
  assumes an APB master that holds each request until pready.
*/
`timescale 1ns/1ps
module dsd_top_chk (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        modClk,
  input wire logic        chan0Enable,
  input wire logic        chan1Enable,
  input wire logic [2:0]  mux0Sel,
  input wire logic [2:0]  mux1Sel
);
  import dsd_pkg::*;
  logic [6:0] gap;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // cycles since last modClk rise; the first rise after reset also lands in range
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gap <= 7'h0;
    end else if ($rose(modClk)) begin
      gap <= 7'h0;
    end else if (gap != 7'h7F) begin
      gap <= gap + 7'h1;
    end
  end
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_err_decode;
    psel && penable && !pready |=> pslverr == (paddr > 8'h30 || paddr[1:0] != 2'h0);
  endproperty
  a_err_decode: assert property (p_err_decode) else $error("pslverr wrong");
  property p_rdata_hold;
    $changed(prdata) |-> pready;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved");
  property p_mux0_range;
    mux0Sel <= MUX0_MAX;
  endproperty
  a_mux0_range: assert property (p_mux0_range) else $error("mux0Sel out of range");
  property p_mux1_range;
    mux1Sel <= MUX1_MAX;
  endproperty
  a_mux1_range: assert property (p_mux1_range) else $error("mux1Sel out of range");
  property p_chan_pair;
    chan1Enable |-> chan0Enable;
  endproperty
  a_chan_pair: assert property (p_chan_pair) else $error("channel 1 on alone");
  property p_mod_period;
    $rose(modClk) |-> gap >= 7'd18 && gap <= 7'd77;
  endproperty
  a_mod_period: assert property (p_mod_period) else $error("modClk period wrong");
endmodule
bind dsd_top dsd_top_chk dsd_top_chk_inst (.clk_sys, .rstn, .psel, .penable, .paddr, .pready, .pslverr,
  .prdata, .modClk, .chan0Enable, .chan1Enable, .mux0Sel, .mux1Sel);

/* tb/dsd_top_bench.sv */
/*
  dsd_top_bench: self-checking bench for dsd_top with the modulator model.
  assumes an APB slave that answers with pready.
*/
`timescale 1ns/1ps
module dsd_top_bench;
  import dsd_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} dsd_row_s;
  logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, rangeOn = 0, modOld = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, q, sum;
  logic [2:0] density = 3'h6, mux0Sel, mux1Sel;
  logic [1:0] ref0Sel, ref1Sel;
  logic pready, pslverr, modBit0, modBit1, rangeErr0, rangeErr1, modClk;
  logic chan0Enable, chan1Enable, chopEnable, irq, e;
  int err_count = 0, checks = 0, sinceRise = 0, lastPer = 0;
  dsd_row_s rows [12] = '{'{1'b0, OFF_MODE, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_CFG0, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFF_CFG1, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_FILT, 32'h0, 32'h0000_001F, 1'b0},
    '{1'b0, OFF_STAT, 32'h0, 32'h0, 1'b0}, '{1'b0, OFF_ACC, 32'h0, 32'h0, 1'b0},
    '{1'b0, OFF_CNT, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h34, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h34, 32'hFFFF_FFFF, 32'h0, 1'b1}, '{1'b0, 8'h06, 32'h0, 32'h0, 1'b1},
    '{1'b1, OFF_CNTLIM, 32'h0000_0005, 32'h0000_0005, 1'b0},
    '{1'b1, OFF_THR, 32'h0007_FFFF, 32'h0007_FFFF, 1'b0}};
  always #50 clk_sys = !clk_sys;
  dsd_top dsd_top_inst (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .modBit0, .modBit1, .rangeErr0, .rangeErr1, .modClk, .chan0Enable, .chan1Enable, .mux0Sel,
    .mux1Sel, .ref0Sel, .ref1Sel, .chopEnable, .irq);
  dsd_mod_model dsd_mod_model_inst (.clk_sys, .rstn, .modClk, .chan0Enable, .chan1Enable, .density,
    .rangeOn, .modBit0, .modBit1, .rangeErr0, .rangeErr1);
  // modClk period in clk_sys cycles
  always @(posedge clk_sys) begin
    modOld <= modClk;
    if (modClk && !modOld) begin
      lastPer   <= sinceRise + 1;
      sinceRise <= 0;
    end else begin
      sinceRise <= sinceRise + 1;
    end
  end
  task automatic end_sim();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic stop(input string n);
    err_count++;
    $display("Error %s expected event seen timeout", n);
    end_sim();
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
    checks++;
    if (s !== x) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask
  // idle cycle after each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) stop("pready");
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 5000 && irq !== 1'b1; n++) @(posedge clk_sys);
    if (n >= 5000) stop("irq");
  endtask
  task automatic wait_st(input int b);
    int n;
    for (n = 0; n < 500; n++) begin
      apb(1'b0, OFF_STAT, 32'h0);
      if (q[b] === 1'b1) break;
    end
    if (n >= 500) stop("status");
  endtask
  task automatic run_rows();
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("readback", rows[i].x, q);
      chk("pslverr", 32'(rows[i].e), 32'(e));
    end
  endtask
  task automatic single(input logic [31:0] fl);
    apb(1'b1, OFF_FILT, fl);
    apb(1'b1, OFF_ICLR, 32'h0000_300F);
    apb(1'b1, OFF_MODE, 32'(MODE_SINGLE));
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    chk("ref0Sel", 32'(REF_EXT), 32'(ref0Sel));
    chk("ref1Sel", 32'(REF_EXT), 32'(ref1Sel));
    run_rows();
    // every mux and reference code, internal reference among them
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFF_CFG0, 32'((i % 4) << CFG_REF_LSB | i));
      apb(1'b1, OFF_CFG1, 32'((3 - i % 4) << CFG_REF_LSB | i));
      chk("mux0Sel", (i <= 4) ? i : 1, 32'(mux0Sel));
      chk("mux1Sel", (i <= 6) ? i : 4, 32'(mux1Sel));
      chk("ref0Sel", i % 4, 32'(ref0Sel));
      chk("ref1Sel", 3 - i % 4, 32'(ref1Sel));
    end
    apb(1'b1, OFF_MODE, 32'h0000_0009);
    repeat (300) @(posedge clk_sys);
    chk("low period", LOWP_MOD_DIV, lastPer);
    chk("chan enables", 32'h1, {chan1Enable, chan0Enable});
    apb(1'b1, OFF_MODE, 32'h0000_0001);
    repeat (300) @(posedge clk_sys);
    chk("full period", NORM_MOD_DIV, lastPer);
    chk("chan enables", 32'h3, {chan1Enable, chan0Enable});
    apb(1'b1, OFF_MODE, 32'h0);
    apb(1'b1, OFF_IEN, 32'h0000_0001);
    apb(1'b1, OFF_CFG0, 32'h0000_0300);
    sum = 32'h0;
    for (int k = 0; k < 2; k++) begin
      single(32'h0000_0004);
      wait_irq();
      apb(1'b0, OFF_RES0, 32'h0);
      chk("res0 width", 32'h0, q & 32'hFFE0_0000);
      sum = sum + {{12{q[19]}}, q[19:0]};
      apb(1'b0, OFF_ACC, 32'h0);
      chk("acc", sum, q);
      apb(1'b0, OFF_MODE, 32'h0);
      chk("mode", 32'(MODE_IDLE), q);
    end
    apb(1'b1, OFF_ICLR, 32'h0000_000F);
    chk("irq clear", 32'h0, 32'(irq));
    apb(1'b1, OFF_IEN, 32'h0);
    single(32'h0000_1004);
    wait_st(ST_RDY0);
    chk("irq masked", 32'h0, 32'(irq));
    rangeOn <= 1'b1;
    single(32'h0000_0004);
    wait_st(ST_RDY0);
    chk("err0", 32'h1, 32'(q[ST_ERR0]));
    apb(1'b0, OFF_RES0, 32'h0);
    chk("invalid", 32'h1, 32'(q[20]));
    rangeOn <= 1'b0;
    apb(1'b1, OFF_CFG0, 32'h0);
    apb(1'b1, OFF_ICLR, 32'h0000_300F);
    apb(1'b1, OFF_CNT, 32'h0);
    apb(1'b1, OFF_MODE, 32'(MODE_CONT));
    wait_st(ST_RDY1);
    apb(1'b0, OFF_CNT, 32'h0);
    chk("settle count", 32'h1, q);
    apb(1'b1, OFF_FILT, 32'h0000_8004);
    chk("chopEnable", 32'h1, 32'(chopEnable));
    apb(1'b1, OFF_IEN, 32'h0000_0004);
    apb(1'b1, OFF_ICLR, 32'h0000_000F);
    wait_irq();
    wait_st(IRQ_CNT);
    apb(1'b1, OFF_IEN, 32'h0000_0008);
    apb(1'b1, OFF_ICLR, 32'h0000_000F);
    repeat (600) @(posedge clk_sys);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("no exceed", 32'h0, 32'(q[IRQ_THR]));
    apb(1'b1, OFF_THR, 32'h0008_0000);
    wait_irq();
    wait_st(IRQ_THR);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    chk("irq reset", 32'h0, 32'(irq));
    run_rows();
    end_sim();
  end
endmodule
